// File: rtl/evsm_regs.svh
`ifndef EVSM_REGS_SVH
`define EVSM_REGS_SVH
// register offsets
`define EVSM_OFS_LIVE 16'h0404
`define EVSM_OFS_MASK 16'h0405
`define EVSM_OFS_FLAGS 16'h0480
`define EVSM_OFS_NLMASK 16'h0481
`define EVSM_OFS_PHNL 16'h0482
// live condition field positions
`define EVSM_LIVE_READY_BIT 16
`define EVSM_LIVE_NL_LSB 10
`define EVSM_LIVE_SIGN_LSB 6
`define EVSM_LIVE_SWELL_LSB 3
`define EVSM_LIVE_DIP_LSB 0
// sticky flag and mask field positions
`define EVSM_FLAG_NL_LSB 0
`define EVSM_FLAG_EV_LSB 18
`define EVSM_MASK_W 26
// event slots inside the upper flag field
`define EVSM_EV_PWR 0
`define EVSM_EV_RMS_HALF 1
`define EVSM_EV_RMS_MULTI 2
`define EVSM_EV_THD_PF 3
`define EVSM_EV_TRIG 4
`define EVSM_EV_WFB_FULL 5
`define EVSM_EV_MISMATCH 6
`define EVSM_EV_TEMP 7
// reset value of every register but live, whose no-load bits read one after reset
`define EVSM_RST_VAL 32'h0000_0000
`endif

// File: rtl/evsm_pkg.sv
`default_nettype none
package evsm_pkg;
    typedef logic [31:0] evsm_word_t;
    typedef enum logic [2:0] {
        EVSM_SEL_NONE,
        EVSM_SEL_LIVE,
        EVSM_SEL_MASK,
        EVSM_SEL_FLAGS,
        EVSM_SEL_NLMASK,
        EVSM_SEL_PHNL
    } evsm_sel_e;
endpackage : evsm_pkg
`default_nettype wire

// File: rtl/evsm_top.sv
// Function
// - each energy type sets a sticky flag when any phase enters or leaves no load
// - record per phase no-load state so software finds the phase that moved
// - live no-load bit per type is high only while all phases are out
// - new-samples bit goes to one when new waveform samples are ready
// - pulse sign bit per output: one positive energy, zero negative
// - pulse sign bit updates only on falling edge of its pulse pin
// - live swell bit per phase, one while that phase is in swell
// - live dip bit per phase, one while that phase is in dip
// - mask bit 25 enables interrupt on new temperature result
// - mask bit 24 enables interrupt on summed current threshold relation change
// - mask bit 23 enables interrupt on resampled buffer full, capture selection zero
// - mask bit 22 enables interrupt on configured buffer trigger event
// - mask bit 21 enables interrupt on distortion and power factor refresh
// - mask bit 20 enables interrupt on ten or twelve cycle rms refresh
// - mask bit 19 enables interrupt on half cycle rms refresh
// - mask bit 18 enables interrupt on power accumulation update
`timescale 1ns/1ps
`default_nettype none
`include "evsm_regs.svh"

module evsm_top
    import evsm_pkg::*;
#(
    parameter int NPH = 3,
    parameter int NTYPE = 6,
    parameter int NPULSE = 4
) (
    input wire logic clock,
    input wire logic rst_b,
    input wire logic clk_en,
    input wire logic [15:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [31:0] reg_wdata,
    output logic [31:0] reg_rdata,
    output logic reg_rvalid,
    input wire logic [NTYPE*NPH-1:0] noload_in,
    input wire logic new_samples_ready,
    input wire logic [NPULSE-1:0] pulse_out,
    input wire logic [NPULSE-1:0] pulse_sign,
    input wire logic [NPH-1:0] phase_swell,
    input wire logic [NPH-1:0] phase_dip,
    input wire logic temp_ready,
    input wire logic summed_current_over,
    input wire logic buffer_full_resampled,
    input wire logic capture_selection,
    input wire logic buffer_trigger,
    input wire logic distortion_pf_ready,
    input wire logic multi_cycle_rms_ready,
    input wire logic half_cycle_rms_ready,
    input wire logic power_accum_ready,
    output logic irq
);

    // field layout fixes these sizes
    if (NPH != 3 || NTYPE != 6 || NPULSE != 4) begin : g_chk
        $error("evsm_top: NPH 3, NTYPE 6, NPULSE 4 only");
    end

    // address decode, shared by read and write paths
    function automatic evsm_sel_e sel_of(input logic [15:0] a);
        case (a)
            `EVSM_OFS_LIVE: sel_of = EVSM_SEL_LIVE;
            `EVSM_OFS_MASK: sel_of = EVSM_SEL_MASK;
            `EVSM_OFS_FLAGS: sel_of = EVSM_SEL_FLAGS;
            `EVSM_OFS_NLMASK: sel_of = EVSM_SEL_NLMASK;
            `EVSM_OFS_PHNL: sel_of = EVSM_SEL_PHNL;
            default: sel_of = EVSM_SEL_NONE;
        endcase
    endfunction : sel_of

    // reset release through two flops; assertion stays asynchronous
    logic rst_q1;
    logic rst_q2;
    logic rst_n;

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            rst_q1 <= 1'b0;
            rst_q2 <= 1'b0;
        end else begin
            rst_q1 <= 1'b1;
            rst_q2 <= rst_q1;
        end
    end
    assign rst_n = rst_q2;

    // pulse pins come from outside: two-flop sync plus history for edges
    logic [NPULSE-1:0] pin_q1;
    logic [NPULSE-1:0] pin_q2;
    logic [NPULSE-1:0] pin_q3;
    logic [NPULSE-1:0] pin_d1;
    logic [NPULSE-1:0] pin_d2;
    logic [NPULSE-1:0] pin_d3;
    logic [NPULSE-1:0] pulse_fall;

    always_comb begin
        pin_d1 = clk_en ? pulse_out : pin_q1;
        pin_d2 = clk_en ? pin_q1 : pin_q2;
        pin_d3 = clk_en ? pin_q2 : pin_q3;
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            pin_q1 <= '0;
            pin_q2 <= '0;
            pin_q3 <= '0;
        end else begin
            pin_q1 <= pin_d1;
            pin_q2 <= pin_d2;
            pin_q3 <= pin_d3;
        end
    end
    assign pulse_fall = pin_q3 & ~pin_q2;

    // access strobes and decoded selects
    evsm_sel_e wsel;
    evsm_sel_e rsel;
    logic wr_go;
    logic rd_go;
    logic w_flags;
    logic w_mask;
    logic w_nlmask;
    logic rd_live;

    assign wr_go = clk_en & reg_wr;
    assign rd_go = clk_en & reg_rd;
    assign wsel = sel_of(reg_addr);
    assign rsel = sel_of(reg_addr);
    assign w_flags = wr_go && (wsel == EVSM_SEL_FLAGS);
    assign w_mask = wr_go && (wsel == EVSM_SEL_MASK);
    assign w_nlmask = wr_go && (wsel == EVSM_SEL_NLMASK);
    assign rd_live = rd_go && (rsel == EVSM_SEL_LIVE);

    // no-load history and transition detect per type
    logic [NTYPE*NPH-1:0] phnl_q;
    logic [NTYPE*NPH-1:0] phnl_d;
    logic [NTYPE-1:0] nl_chg;

    for (genvar t = 0; t < NTYPE; t++) begin : g_nl
        assign nl_chg[t] = |(noload_in[t*NPH +: NPH] ^ phnl_q[t*NPH +: NPH]);
    end

    // snapshot tracks live phases, so the moving phase stays visible
    always_comb begin
        phnl_d = clk_en ? noload_in : phnl_q;
    end

    // threshold relation history for change detect
    logic over_q;
    logic over_d;
    logic over_chg;

    always_comb begin
        over_d = clk_en ? summed_current_over : over_q;
    end
    assign over_chg = over_d ^ over_q;

    // upper event sources in flag slot order
    logic [7:0] ev_set;

    always_comb begin
        ev_set = '0;
        ev_set[`EVSM_EV_PWR] = power_accum_ready;
        ev_set[`EVSM_EV_RMS_HALF] = half_cycle_rms_ready;
        ev_set[`EVSM_EV_RMS_MULTI] = multi_cycle_rms_ready;
        ev_set[`EVSM_EV_THD_PF] = distortion_pf_ready;
        ev_set[`EVSM_EV_TRIG] = buffer_trigger;
        // full only counts for resampled capture
        ev_set[`EVSM_EV_WFB_FULL] = buffer_full_resampled & ~capture_selection;
        ev_set[`EVSM_EV_MISMATCH] = over_chg;
        ev_set[`EVSM_EV_TEMP] = temp_ready;
    end

    // sticky flags: set wins over a same-cycle clear
    logic [NTYPE-1:0] nlflag_q;
    logic [NTYPE-1:0] nlflag_d;
    logic [7:0] evflag_q;
    logic [7:0] evflag_d;
    logic [NTYPE-1:0] nl_clr;
    logic [7:0] ev_clr;

    assign nl_clr = w_flags ? reg_wdata[`EVSM_FLAG_NL_LSB +: NTYPE] : '0;
    assign ev_clr = w_flags ? reg_wdata[`EVSM_FLAG_EV_LSB +: 8] : '0;

    always_comb begin
        nlflag_d = nlflag_q;
        evflag_d = evflag_q;
        if (clk_en) begin
            nlflag_d = (nlflag_q & ~nl_clr) | nl_chg;
            evflag_d = (evflag_q & ~ev_clr) | ev_set;
        end
    end

    // masks: upper mask register plus the no-load mask
    logic [`EVSM_MASK_W-1:0] mask_q;
    logic [`EVSM_MASK_W-1:0] mask_d;
    logic [NTYPE-1:0] nlmask_q;
    logic [NTYPE-1:0] nlmask_d;

    always_comb begin
        mask_d = w_mask ? reg_wdata[`EVSM_MASK_W-1:0] : mask_q;
        nlmask_d = w_nlmask ? reg_wdata[NTYPE-1:0] : nlmask_q;
    end

    // live condition bits
    logic [NPULSE-1:0] sign_q;
    logic [NPULSE-1:0] sign_d;
    logic ready_q;
    logic ready_d;
    logic [NPH-1:0] swell_q;
    logic [NPH-1:0] swell_d;
    logic [NPH-1:0] dip_q;
    logic [NPH-1:0] dip_d;
    logic [NTYPE-1:0] nl_out;

    for (genvar t = 0; t < NTYPE; t++) begin : g_out
        assign nl_out[t] = ~|phnl_q[t*NPH +: NPH];
    end

    always_comb begin
        sign_d = sign_q;
        ready_d = ready_q;
        swell_d = swell_q;
        dip_d = dip_q;
        if (clk_en) begin
            for (int i = 0; i < NPULSE; i++) begin
                if (pulse_fall[i]) begin
                    sign_d[i] = pulse_sign[i];
                end
            end
            // cleared by reading, so the next rise is seen again
            ready_d = (ready_q & ~rd_live) | new_samples_ready;
            swell_d = phase_swell;
            dip_d = phase_dip;
        end
    end

    // assembled register images
    evsm_word_t live_word;
    evsm_word_t flag_word;

    always_comb begin
        live_word = `EVSM_RST_VAL;
        live_word[`EVSM_LIVE_READY_BIT] = ready_q;
        live_word[`EVSM_LIVE_NL_LSB +: NTYPE] = nl_out;
        live_word[`EVSM_LIVE_SIGN_LSB +: NPULSE] = sign_q;
        live_word[`EVSM_LIVE_SWELL_LSB +: NPH] = swell_q;
        live_word[`EVSM_LIVE_DIP_LSB +: NPH] = dip_q;
        flag_word = `EVSM_RST_VAL;
        flag_word[`EVSM_FLAG_NL_LSB +: NTYPE] = nlflag_q;
        flag_word[`EVSM_FLAG_EV_LSB +: 8] = evflag_q;
    end

    // read port: data held until the next read
    evsm_word_t rdata_q;
    evsm_word_t rdata_d;
    logic rvalid_q;
    logic rvalid_d;

    always_comb begin
        rdata_d = rdata_q;
        rvalid_d = clk_en ? reg_rd : rvalid_q;
        if (rd_go) begin
            case (rsel)
                EVSM_SEL_LIVE: rdata_d = live_word;
                EVSM_SEL_MASK: rdata_d = {{(32-`EVSM_MASK_W){1'b0}}, mask_q};
                EVSM_SEL_FLAGS: rdata_d = flag_word;
                EVSM_SEL_NLMASK: rdata_d = {{(32-NTYPE){1'b0}}, nlmask_q};
                EVSM_SEL_PHNL: rdata_d = {{(32-NTYPE*NPH){1'b0}}, phnl_q};
                default: rdata_d = `EVSM_RST_VAL; // unmapped reads zero
            endcase
        end
    end

    // interrupt from next flag state, registered
    logic irq_q;
    logic irq_d;

    always_comb begin
        irq_d = irq_q;
        if (clk_en) begin
            irq_d = |(nlflag_d & nlmask_d)
                | |(evflag_d & mask_d[`EVSM_FLAG_EV_LSB +: 8]);
        end
    end

    // state registers; everything clears to zero
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            phnl_q <= '0;
            over_q <= 1'b0;
            nlflag_q <= '0;
            evflag_q <= '0;
            mask_q <= '0;
            nlmask_q <= '0;
            sign_q <= '0;
            ready_q <= 1'b0;
            swell_q <= '0;
            dip_q <= '0;
            rdata_q <= `EVSM_RST_VAL;
            rvalid_q <= 1'b0;
            irq_q <= 1'b0;
        end else begin
            phnl_q <= phnl_d;
            over_q <= over_d;
            nlflag_q <= nlflag_d;
            evflag_q <= evflag_d;
            mask_q <= mask_d;
            nlmask_q <= nlmask_d;
            sign_q <= sign_d;
            ready_q <= ready_d;
            swell_q <= swell_d;
            dip_q <= dip_d;
            rdata_q <= rdata_d;
            rvalid_q <= rvalid_d;
            irq_q <= irq_d;
        end
    end

    assign reg_rdata = rdata_q;
    assign reg_rvalid = rvalid_q;
    assign irq = irq_q;

endmodule : evsm_top

`default_nettype wire

// File: sim/evsm_props.sv
`timescale 1ns/1ps
`default_nettype none
module evsm_props
    import evsm_pkg::*;
#(
    parameter int NPH = 3,
    parameter int NTYPE = 6,
    parameter int NPULSE = 4
) (
    input wire logic clock,
    input wire logic rst_b,
    input wire logic clk_en,
    input wire logic [15:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [31:0] reg_wdata,
    input wire logic [31:0] reg_rdata,
    input wire logic [NTYPE*NPH-1:0] noload_in,
    input wire logic new_samples_ready,
    input wire logic [NPH-1:0] phase_swell,
    input wire logic [NPH-1:0] phase_dip,
    input wire logic temp_ready,
    input wire logic summed_current_over,
    input wire logic buffer_full_resampled,
    input wire logic capture_selection,
    input wire logic power_accum_ready,
    input wire logic irq
);
    logic [1:0] up_q, up_d;
    logic ok;
    logic [NTYPE-1:0] all_out;
    // edge count after release; the design's reset synchroniser hides the first edges
    always_comb begin
        up_d = (up_q == 2'h3) ? up_q : up_q + 2'h1;
        ok = (up_q == 2'h3) && clk_en;
        for (int t = 0; t < NTYPE; t++) all_out[t] = ~|noload_in[t*NPH+:NPH];
    end
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) up_q <= 2'h0;
        else up_q <= up_d;
    end
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_b);
    // live image lags inputs one edge, so a read returns inputs two edges back
    sequence s_rd_live;
        ok && $past(clk_en) && reg_rd && reg_addr == 16'h0404;
    endsequence
    sequence s_mask(int b);
        ok && reg_wr && reg_addr == 16'h0405 && reg_wdata[b];
    endsequence
    property p_noload; s_rd_live |=> reg_rdata[15:10] == $past(all_out, 2); endproperty
    a_noload: assert property (p_noload) else $error("no-load bits wrong");
    property p_swell; s_rd_live |=> reg_rdata[5:3] == $past(phase_swell, 2); endproperty
    a_swell: assert property (p_swell) else $error("swell bits wrong");
    property p_dip; s_rd_live |=> reg_rdata[2:0] == $past(phase_dip, 2); endproperty
    a_dip: assert property (p_dip) else $error("dip bits wrong");
    property p_ready; (ok && new_samples_ready) ##1 s_rd_live |=> reg_rdata[16]; endproperty
    a_ready: assert property (p_ready) else $error("new samples bit missing");
    // event and enabling write in one cycle must still raise irq at once
    property p_temp; s_mask(25) ##0 temp_ready |=> irq; endproperty
    a_temp: assert property (p_temp) else $error("no irq on temperature");
    property p_mism;
        s_mask(24) ##0 ($past(clk_en) && summed_current_over != $past(summed_current_over)) |=> irq;
    endproperty
    a_mism: assert property (p_mism) else $error("no irq on mismatch change");
    property p_wfb; s_mask(23) ##0 (buffer_full_resampled && !capture_selection) |=> irq; endproperty
    a_wfb: assert property (p_wfb) else $error("no irq on buffer full");
    property p_pwr; s_mask(18) ##0 power_accum_ready |=> irq; endproperty
    a_pwr: assert property (p_pwr) else $error("no irq on power update");
endmodule : evsm_props
bind evsm_top evsm_props #(.NPH(NPH), .NTYPE(NTYPE), .NPULSE(NPULSE)) u_props (.clock, .rst_b, .clk_en,
    .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata, .noload_in, .new_samples_ready, .phase_swell, .phase_dip,
    .temp_ready, .summed_current_over, .buffer_full_resampled, .capture_selection, .power_accum_ready, .irq);
`default_nettype wire

// File: sim/evsm_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module evsm_tb_top import evsm_pkg::*;;
    logic clock, rst_b, clk_en, reg_wr, reg_rd, reg_rvalid, irq, capture_selection, new_samples_ready;
    logic [15:0] reg_addr;
    evsm_word_t reg_wdata, reg_rdata;
    logic [17:0] noload_in;
    logic [7:0] ev;
    logic [3:0] pulse_out, pulse_sign;
    logic [2:0] phase_swell, phase_dip;
    int miscompares, n_compared;
    // event slots follow the mask bit order 18 upwards
    evsm_top dut (.clock, .rst_b, .clk_en, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata, .reg_rvalid,
        .noload_in, .new_samples_ready, .pulse_out, .pulse_sign, .phase_swell, .phase_dip, .capture_selection,
        .temp_ready(ev[7]), .summed_current_over(ev[6]), .buffer_full_resampled(ev[5]), .buffer_trigger(ev[4]),
        .distortion_pf_ready(ev[3]), .multi_cycle_rms_ready(ev[2]), .half_cycle_rms_ready(ev[1]),
        .power_accum_ready(ev[0]), .irq);
    task automatic end_sim;
        $display("compared %0d, mismatches %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : end_sim
    task automatic chk(input evsm_word_t got, input evsm_word_t exp);
        n_compared++;
        if (got !== exp) begin
            miscompares++;
            $display("Error at %0t ns: got %h, expected %h", $time, got, exp);
        end
    endtask : chk
    // extra idle cycle so back-to-back writes never touch the strobe twice in one step
    task automatic wr(input logic [15:0] a, input evsm_word_t v);
        reg_addr = a;
        reg_wdata = v;
        reg_wr = 1'b1;
        @(negedge clock);
        reg_wr = 1'b0;
        @(negedge clock);
    endtask : wr
    task automatic rc(input logic [15:0] a, input evsm_word_t e);
        reg_addr = a;
        reg_rd = 1'b1;
        @(negedge clock);
        reg_rd = 1'b0;
        // valid stands for exactly the cycle after the taken read
        chk({31'h0, reg_rvalid}, 32'h1);
        @(negedge clock);
        chk({31'h0, reg_rvalid}, 32'h0);
        chk(reg_rdata, e);
    endtask : rc
    // event raised in the same cycle as a mask write
    task automatic fire(input int i, input evsm_word_t m);
        ev[i] = 1'b1;
        wr(16'h0405, m);
        ev[i] = 1'b0;
    endtask : fire
    initial begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end
    // whole run is under two hundred cycles; this only catches a hang
    initial begin
        repeat (3000) @(posedge clock);
        miscompares++;
        end_sim();
    end
    initial begin
        {rst_b, reg_wr, reg_rd, ev, capture_selection, new_samples_ready} = '0;
        {reg_addr, reg_wdata, noload_in, pulse_sign, phase_swell, phase_dip} = '0;
        clk_en = 1'b1;
        pulse_out = 4'hf;
        repeat (3) @(negedge clock);
        rst_b = 1'b1;
        repeat (4) @(negedge clock);
        // no phase is in no load, so every live no-load bit already reads one
        rc(16'h0404, 32'h0000_fc00);
        rc(16'h0480, 32'h0);
        rc(16'h0405, 32'h0);
        rc(16'h0400, 32'h0); // unmapped address reads zero
        $display("test reset done");
        noload_in = 18'h00407;
        phase_swell = 3'h2;
        phase_dip = 3'h5;
        repeat (2) @(negedge clock);
        wr(16'h0404, 32'hffff_ffff);
        rc(16'h0404, 32'h0000_d815);
        rc(16'h0482, 32'h0000_0407);
        rc(16'h0480, 32'h0000_0009);
        wr(16'h0480, 32'h0000_0001);
        rc(16'h0480, 32'h0000_0008);
        wr(16'h0480, 32'h0);
        rc(16'h0480, 32'h0000_0008);
        // the flag sets one edge after the change; a read on that edge still returns the old word
        noload_in = 18'h0;
        @(negedge clock);
        rc(16'h0480, 32'h0000_0009);
        wr(16'h0480, 32'hffff_ffff);
        $display("test live done");
        new_samples_ready = 1'b1;
        @(negedge clock);
        new_samples_ready = 1'b0;
        rc(16'h0404, 32'h0001_fc15);
        rc(16'h0404, 32'h0000_fc15);
        // pins 1 and 3 fall; pins 0 and 2 stay high and must ignore their sign
        pulse_sign = 4'hf;
        pulse_out = 4'h5;
        repeat (5) @(negedge clock);
        rc(16'h0404, 32'h0000_fe95);
        pulse_sign = 4'h0;
        pulse_out = 4'hf;
        repeat (5) @(negedge clock);
        rc(16'h0404, 32'h0000_fe95);
        pulse_out = 4'h0;
        repeat (5) @(negedge clock);
        rc(16'h0404, 32'h0000_fc15);
        $display("test pulse sign done");
        wr(16'h0405, 32'hffff_ffff);
        rc(16'h0405, 32'h03ff_ffff);
        for (int i = 0; i < 8; i++) begin
            fire(i, 32'h0);
            rc(16'h0480, 32'h1 << (18 + i));
            chk({31'h0, irq}, 32'h0);
            wr(16'h0480, 32'hffff_ffff);
            fire(i, 32'h1 << (18 + i));
            chk({31'h0, irq}, 32'h1);
            wr(16'h0405, 32'h0);
            chk({31'h0, irq}, 32'h0);
            wr(16'h0480, 32'hffff_ffff);
        end
        capture_selection = 1'b1;
        fire(5, 32'h0);
        rc(16'h0480, 32'h0);
        $display("test irq done");
        // no-load flags reach irq through their own mask
        wr(16'h0481, 32'hffff_ffff);
        rc(16'h0481, 32'h0000_003f);
        noload_in = 18'h2_0000;
        @(negedge clock);
        chk({31'h0, irq}, 32'h1);
        rc(16'h0404, 32'h0000_7c15);
        rc(16'h0482, 32'h0002_0000);
        wr(16'h0480, 32'h0000_0020);
        chk({31'h0, irq}, 32'h0);
        // frozen block ignores the write and the transition until enable returns
        clk_en = 1'b0;
        noload_in = 18'h0;
        wr(16'h0481, 32'h0);
        chk({31'h0, irq}, 32'h0);
        clk_en = 1'b1;
        rc(16'h0481, 32'h0000_003f);
        chk({31'h0, irq}, 32'h1);
        rc(16'h0480, 32'h0000_0020);
        $display("test no-load mask done");
        // reset in mid-run clears read data, valid and interrupt at once
        rst_b = 1'b0;
        @(negedge clock);
        chk(reg_rdata, 32'h0);
        chk({31'h0, reg_rvalid}, 32'h0);
        chk({31'h0, irq}, 32'h0);
        rst_b = 1'b1;
        repeat (4) @(negedge clock);
        rc(16'h0480, 32'h0);
        rc(16'h0481, 32'h0);
        $display("test second reset done");
        end_sim();
    end
endmodule : evsm_tb_top
`default_nettype wire
